// ===== bench/sbcig_checker.sv
`timescale 1ns/1ps
`include "sbcig_defs.vh"
module sbcig_checker (
    input wire logic        clk, rst, cpu_sync, step_limit_jumper, tape_in,
    input wire logic        write_protect_request, printer_ack_n, cpu_nmi,
    input wire logic        display_ack_n, kbd_ca2, bank_select, kbd_ca1,
    input wire logic        bank_select_n, dma_terminate, sys_port_reset,
    input wire logic        sys_ca1, sys_cb1, sys_cb2, tape_out,
    input wire logic        tape_relay1, tape_relay2,
    input wire logic        printer_strobe_n, display_strobe_n,
    input wire logic [15:0] cpu_addr,
    input wire logic [7:0]  sys_port_b, sys_port_a, kbd_port_b, periph_data,
    input wire logic [7:0]  key_return_lines,
    input wire logic [8:0]  key_strobe_lines
);
    logic armed;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // first edge after reset still shows reset values
    always @(posedge clk or posedge rst) armed <= !rst;
    bank_sel_a: assert property (armed |->
        bank_select == $past(sys_port_b[2]) && bank_select_n == !bank_select)
        else $error("bank select wrong");
    dma_term_a: assert property (armed |->
        dma_terminate == ($past(sys_port_b[6]) | $past(sys_port_reset)))
        else $error("dma terminate wrong");
    port_ca1_a: assert property (armed |->
        sys_ca1 == ($past(write_protect_request) | !$past(printer_ack_n)))
        else $error("ca1 wrong");
    tape_path_a: assert property (armed |-> tape_out == $past(sys_port_b[7])
        && {tape_relay2, tape_relay1} == $past(sys_port_b[5:4])
        && sys_cb1 == $past(tape_in)) else $error("tape path wrong");
    strobe_map_a: assert property (armed |->
        {printer_strobe_n, display_strobe_n} == $past(sys_port_b[1:0])
        && sys_cb2 == !$past(display_ack_n)) else $error("strobe wrong");
    periph_data_a: assert property (armed |->
        periph_data == $past(sys_port_a)) else $error("data wrong");
    key_lines_a: assert property (armed |->
        key_strobe_lines == {$past(kbd_ca2), $past(kbd_port_b)}
        && kbd_ca1 == ($past(key_return_lines) != 8'hFF))
        else $error("keyboard lines wrong");
    step_nmi_a: assert property (cpu_sync && sys_port_b[3] &&
        cpu_addr < (step_limit_jumper ? `SBCIG_STEP_LIMIT_FIT
        : `SBCIG_STEP_LIMIT_OPEN) |=> cpu_nmi) else $error("no step nmi");
endmodule // sbcig_checker

bind sbcig_glue sbcig_checker sbcig_checker_inst (.*);

// ===== bench/sbcig_cpu.sv
`timescale 1ns/1ps
module sbcig_cpu (
    input  wire logic   clk,
    output logic [15:0] cpu_addr,
    output logic [7:0]  cpu_wdata,
    output logic        cpu_wr,
    output logic        cpu_sync
);
    initial {cpu_addr, cpu_wdata, cpu_wr, cpu_sync} = 26'h0;
    // one bus cycle, held through the single edge that takes it
    task automatic cycle(input logic [15:0] a, input logic [7:0] d,
                         input logic w, input logic s);
        {cpu_addr, cpu_wdata, cpu_wr, cpu_sync} = {a, d, w, s};
        @(posedge clk);
        #2;
        // bus idle: address and data show the inverse, write and sync drop low
        {cpu_addr, cpu_wdata, cpu_wr, cpu_sync} = {~a, ~d, 2'b00};
    endtask
endmodule // sbcig_cpu

// ===== bench/tb.sv
`timescale 1ns/1ps
`define CK(n, e, a) begin check_count++; if ((a) !== (e)) begin \
    fail_count++; $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module tb;
    logic clk = 0, rst = 1, tape_in = 0, kbd_ca2 = 0, sys_port_reset = 0;
    logic step_limit_jumper = 0, attention_route_cb1 = 0;
    logic attention_switch_n = 1, printer_ack_n = 1, display_ack_n = 1;
    logic write_protect_request = 0, serial_adapter_request = 0;
    logic keypad_port_request = 0, user_port_request = 0;
    logic system_port_request = 0, expansion_request = 0;
    logic [17:0] priority_assign_header = 18'h2C688;
    logic [7:0]  sys_port_b = 8'h00, sys_port_a = 8'h00, kbd_port_b = 8'h00;
    logic [7:0]  key_return_lines = 8'hFF, v;
    logic [18:0] st [5] = '{19'h69FFF, 19'h2A000, 19'h39000, 19'h78FFF,
                            19'h10000};
    wire  [15:0] cpu_addr;
    wire  [8:0]  key_strobe_lines;
    wire  [7:0]  cpu_wdata, periph_data;
    wire  cpu_wr, cpu_sync, cpu_irq, cpu_nmi, bank_select, bank_select_n;
    wire  dma_terminate, sys_ca1, sys_cb1, sys_cb2, tape_out, kbd_ca1;
    wire  tape_relay1, tape_relay2, printer_strobe_n, display_strobe_n;
    wire  kbd_cb1;
    int   fail_count = 0, check_count = 0, i, j;
    always #12.5 clk = ~clk;
    sbcig_glue #(.DEBOUNCE_CYC(4)) sbcig_glue_inst (.*);
    sbcig_cpu sbcig_cpu_inst (.*);
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic reqs(input logic [5:0] r);
        {expansion_request, system_port_request, user_port_request,
         keypad_port_request, serial_adapter_request,
         write_protect_request} = r;
    endtask
    task automatic final_report;
        if (fail_count == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        tick(3);
        `CK("dmat rst", 1'b1, dma_terminate)
        `CK("strobe rst", 9'h1FF, key_strobe_lines)
        rst = 0;
        reqs(6'h01);
        tick(1);
        `CK("irq open", 1'b1, cpu_irq)
        for (i = 1; i <= 6; i++) begin
            v = 8'hC0 | (8'h01 << (i - 1));
            sbcig_cpu_inst.cycle({12'hFF8, 4'(i)}, v, 1'b1, 1'b0);
            for (j = 0; j < 6; j++) begin
                reqs(6'(1 << j));
                tick(1);
                `CK("irq ladder", j >= i, cpu_irq)
            end
        end
        reqs(6'h3F);
        sbcig_cpu_inst.cycle(16'hFFA0, 8'h00, 1'b1, 1'b0);
        tick(1);
        `CK("irq foreign", 1'b0, cpu_irq)
        sbcig_cpu_inst.cycle(16'hFF9F, 8'h00, 1'b1, 1'b0);
        tick(1);
        `CK("irq clear", 1'b1, cpu_irq)
        priority_assign_header = 18'h0468D;
        sbcig_cpu_inst.cycle(16'hFF80, 8'h10, 1'b1, 1'b0);
        for (j = 0; j < 6; j += 5) begin
            reqs(6'(1 << j));
            tick(1);
            `CK("irq remap", j == 0, cpu_irq)
        end
        for (i = 0; i < 2; i++) begin
            v = i ? 8'h5A : 8'hA5;
            {sys_port_b, sys_port_a, kbd_port_b, kbd_ca2} = {v, ~v, v, v[0]};
            {tape_in, display_ack_n} = v[4:3];
            reqs({5'h00, v[3]});
            key_return_lines = v[0] ? 8'hFF : 8'hFB;
            tick(1);
            `CK("bank", {v[2], !v[2]}, {bank_select, bank_select_n})
            `CK("dmat", v[6], dma_terminate)
            `CK("tape", {v[7], v[4]}, {tape_out, sys_cb1})
            `CK("relays", v[5:4], {tape_relay2, tape_relay1})
            `CK("strb", v[1:0], {printer_strobe_n, display_strobe_n})
            `CK("ack", !v[3], sys_cb2)
            `CK("wp", v[3], sys_ca1)
            `CK("data", ~v, periph_data)
            `CK("keys", {v[0], v}, key_strobe_lines)
            `CK("keydown", !v[0], kbd_ca1)
        end
        for (i = 0; i < 5; i++) begin
            sys_port_b = {4'h0, st[i][17], 3'h0};
            step_limit_jumper = st[i][16];
            sbcig_cpu_inst.cycle(st[i][15:0], 8'h00, 1'b0, 1'b1);
            `CK("step nmi", st[i][18], cpu_nmi)
        end
        attention_switch_n = 1'b0;
        for (i = 0; i < 20 && cpu_nmi !== 1'b1; i++)
            tick(1);
        `CK("attn nmi", 1'b1, cpu_nmi)
        if (i == 20)
            final_report;
        attention_route_cb1 = 1'b1;
        tick(1);
        `CK("attn cb1", 2'b01, {cpu_nmi, kbd_cb1})
        final_report;
    end
endmodule // tb

// ===== hdl/sbcig_defs.vh
`ifndef SBCIG_DEFS_VH
`define SBCIG_DEFS_VH
// ----------------------------------------
// register map
// ----------------------------------------
`define SBCIG_MASK_ADDR      16'hFF80
`define SBCIG_MASK_DEC_MASK  16'hFFE0
`define SBCIG_MASK_RESET     6'h00
// ----------------------------------------
// step limits
// ----------------------------------------
`define SBCIG_STEP_LIMIT_OPEN 16'hA000
`define SBCIG_STEP_LIMIT_FIT  16'h9000
// ----------------------------------------
// system port b bit positions
// ----------------------------------------
`define SBCIG_PB_DISP_STB 0
`define SBCIG_PB_PRN_STB  1
`define SBCIG_PB_BANK     2
`define SBCIG_PB_STEP     3
`define SBCIG_PB_RELAY1   4
`define SBCIG_PB_RELAY2   5
`define SBCIG_PB_DMAT     6
`define SBCIG_PB_TAPE     7
// ----------------------------------------
// request source indices
// ----------------------------------------
`define SBCIG_SRC_WP   0
`define SBCIG_SRC_SER  1
`define SBCIG_SRC_KEY  2
`define SBCIG_SRC_USR  3
`define SBCIG_SRC_SYS  4
`define SBCIG_SRC_EXP  5
// ----------------------------------------
// debounce
// ----------------------------------------
`define SBCIG_DEBOUNCE_US    10
`define SBCIG_CLK_MHZ        40
`define SBCIG_DEBOUNCE_CYC   (`SBCIG_DEBOUNCE_US * `SBCIG_CLK_MHZ)
`endif

// ===== hdl/sbcig_glue.v
// Functional notes
// - six request inputs feed the prioritizer
// - pass only requests above masked level
// - top level request is tied low, so it never reaches processor
// - latch bit n-1 gates level n
// - set mask bit blocks its level and below
// - source-to-level assignment is configurable
// - step nmi per instruction below jumper limit
// - port b bit 3 selects run or step
// - bank select from port b bit 2, plus inverse
// - dma terminate from port b bit 6, reset too
// - write protect hits prioritizer and port a cl1
// - tape out pb7, tape in to cb1
// - pb4, pb5 drive tape relays one, two
// - printer and display strobes and acks mapped
// - port a byte is shared display/printer data
// - nine strobes copied from kbd_ca2 and kbd port b, eight returns
// - key-down high when any return low
// - attention switch debounced to nmi or cb1
`timescale 1ns/1ps
`include "sbcig_defs.vh"

module sbcig_glue #(
    parameter DEBOUNCE_CYC = `SBCIG_DEBOUNCE_CYC
) (
    input  wire        clk,
    input  wire        rst,
    // cpu bus
    input  wire [15:0] cpu_addr,
    input  wire [7:0]  cpu_wdata,
    input  wire        cpu_wr,
    input  wire        cpu_sync,
    // request sources, active high
    input  wire        write_protect_request,
    input  wire        serial_adapter_request,
    input  wire        keypad_port_request,
    input  wire        user_port_request,
    input  wire        system_port_request,
    input  wire        expansion_request,
    // level k+1 takes source priority_assign_header[3k+2:3k]
    input  wire [17:0] priority_assign_header,
    // system port controller pins
    input  wire [7:0]  sys_port_b,
    input  wire [7:0]  sys_port_a,
    input  wire        sys_port_reset,
    // keyboard port controller pins
    input  wire [7:0]  kbd_port_b,
    input  wire        kbd_ca2,
    input  wire [7:0]  key_return_lines,
    // jumpers and switches
    input  wire        step_limit_jumper,
    input  wire        attention_route_cb1,
    input  wire        attention_switch_n,
    // peripheral acks, active low, and tape in
    input  wire        printer_ack_n,
    input  wire        display_ack_n,
    input  wire        tape_in,
    // outputs
    output reg         cpu_irq,
    output reg         cpu_nmi,
    output reg         bank_select,
    output reg         bank_select_n,
    output reg         dma_terminate,
    output reg         sys_ca1,
    output reg         sys_cb1,
    output reg         sys_cb2,
    output reg         tape_out,
    output reg         tape_relay1,
    output reg         tape_relay2,
    output reg         printer_strobe_n,
    output reg         display_strobe_n,
    output reg  [7:0]  periph_data,
    output reg  [8:0]  key_strobe_lines,
    output reg         kbd_ca1,
    output reg         kbd_cb1
);

    // ----------------------------------------
    // mask latch
    // ----------------------------------------
    reg  [5:0] irq_level_mask_latch;
    wire       mask_sel = ((cpu_addr & `SBCIG_MASK_DEC_MASK) ==
                           `SBCIG_MASK_ADDR);

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_level_mask_latch <= `SBCIG_MASK_RESET;
        end else if (cpu_wr && mask_sel) begin
            irq_level_mask_latch <= cpu_wdata[5:0];
        end
    end

    // ----------------------------------------
    // prioritizer ladder
    // ----------------------------------------
    wire [5:0] src = {expansion_request, system_port_request,
                      user_port_request, keypad_port_request,
                      serial_adapter_request,
                      write_protect_request};

    function src_pick;
        input [5:0] s;
        input [2:0] idx;
        begin
            src_pick = (idx < 3'h6) ? s[idx] : 1'b0;
        end
    endfunction

    reg  [6:0] level_req;
    reg        top_level_request;
    reg        next_irq;
    reg        blocked;
    integer    k;

    always @* begin
        level_req = 7'h00;
        for (k = 0; k < 6; k = k + 1) begin
            level_req[k] = src_pick(src,
                priority_assign_header[3*k +: 3]);
        end
        // no spare header position; top level request is tied low
        top_level_request = 1'b0;
        level_req[6] = top_level_request;
        next_irq = level_req[6];
        blocked  = 1'b0;
        for (k = 5; k >= 0; k = k - 1) begin
            blocked = blocked | irq_level_mask_latch[k];
            if (level_req[k] && !blocked) begin
                next_irq = 1'b1;
            end
        end
    end

    // ----------------------------------------
    // attention debounce
    // ----------------------------------------
    reg [15:0] deb_cnt;
    reg        attn_state;
    wire       attn_raw = ~attention_switch_n;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            deb_cnt    <= 16'h0000;
            attn_state <= 1'b0;
        end else if (attn_raw == attn_state) begin
            deb_cnt <= 16'h0000;
        end else if (deb_cnt >= DEBOUNCE_CYC[15:0] - 16'h0001) begin
            attn_state <= attn_raw;
            deb_cnt    <= 16'h0000;
        end else begin
            deb_cnt <= deb_cnt + 16'h0001;
        end
    end

    // ----------------------------------------
    // step logic
    // ----------------------------------------
    // one nmi pulse per opcode fetch keeps it per-instruction
    wire [15:0] step_limit = step_limit_jumper ?
                             `SBCIG_STEP_LIMIT_FIT :
                             `SBCIG_STEP_LIMIT_OPEN;
    wire step_mode = sys_port_b[`SBCIG_PB_STEP];
    wire step_hit  = step_mode && cpu_sync &&
                     (cpu_addr < step_limit);
    wire attn_nmi  = attn_state && !attention_route_cb1;

    // ----------------------------------------
    // interrupt outputs
    // ----------------------------------------
    // registered, so a request shows one cycle after it arrives
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cpu_irq <= 1'b0;
            cpu_nmi <= 1'b0;
        end else begin
            cpu_irq <= next_irq;
            cpu_nmi <= step_hit | attn_nmi;
        end
    end

    // ----------------------------------------
    // bank select and dma terminate
    // ----------------------------------------
    // dma terminate rests high so a reset ends any transfer
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            bank_select   <= 1'b0;
            bank_select_n <= 1'b1;
            dma_terminate <= 1'b1;
        end else begin
            bank_select   <= sys_port_b[`SBCIG_PB_BANK];
            bank_select_n <= ~sys_port_b[`SBCIG_PB_BANK];
            dma_terminate <= sys_port_reset |
                             sys_port_b[`SBCIG_PB_DMAT];
        end
    end

    // ----------------------------------------
    // system port control lines
    // ----------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sys_ca1 <= 1'b0;
            sys_cb1 <= 1'b0;
            sys_cb2 <= 1'b0;
        end else begin
            // write protect and printer ack share this line
            sys_ca1 <= write_protect_request |
                       ~printer_ack_n;
            sys_cb1 <= tape_in;
            sys_cb2 <= ~display_ack_n;
        end
    end

    // ----------------------------------------
    // tape interface
    // ----------------------------------------
    // bit timing is left to software, so no shaping here
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            tape_out    <= 1'b0;
            tape_relay1 <= 1'b0;
            tape_relay2 <= 1'b0;
        end else begin
            tape_out    <= sys_port_b[`SBCIG_PB_TAPE];
            tape_relay1 <= sys_port_b[`SBCIG_PB_RELAY1];
            tape_relay2 <= sys_port_b[`SBCIG_PB_RELAY2];
        end
    end

    // ----------------------------------------
    // printer and display interface
    // ----------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            printer_strobe_n <= 1'b1;
            display_strobe_n <= 1'b1;
            periph_data      <= 8'h00;
        end else begin
            printer_strobe_n <= sys_port_b[`SBCIG_PB_PRN_STB];
            display_strobe_n <= sys_port_b[`SBCIG_PB_DISP_STB];
            periph_data      <= sys_port_a;
        end
    end

    // ----------------------------------------
    // keyboard interface
    // ----------------------------------------
    // strobes idle high so no key reads as pressed after reset
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            key_strobe_lines <= 9'h1FF;
            kbd_ca1          <= 1'b0;
            kbd_cb1          <= 1'b0;
        end else begin
            key_strobe_lines <= {kbd_ca2, kbd_port_b};
            kbd_ca1          <= ~(&key_return_lines);
            kbd_cb1          <= attn_state && attention_route_cb1;
        end
    end

endmodule // sbcig_glue
